// ==== inc/masic_pkg.sv ====
package masic_pkg;
    // avalon word offsets (byte address = 4 * index)
    localparam logic [3:0] MASIC_REG_ADC_CTRL = 4'h0;
    localparam logic [3:0] MASIC_REG_ADC_DIS = 4'h1;
    localparam logic [3:0] MASIC_REG_PIN_CTRL = 4'h2;
    localparam logic [3:0] MASIC_REG_STATUS = 4'h3;
    localparam logic [3:0] MASIC_REG_FLAG = 4'h4;
    localparam logic [3:0] MASIC_REG_MASK = 4'h5;
    localparam logic [3:0] MASIC_REG_RESULT0 = 4'h8;
    localparam int MASIC_NUM_CH = 8;
    localparam int MASIC_RES_W = 16;
    // adc control fields
    localparam int MASIC_ADC_EN_BIT = 0;
    localparam int MASIC_ADC_ONESHOT_BIT = 1;
    localparam int MASIC_ADC_SAMPLE_LSB = 2;
    localparam int MASIC_ADC_SAMPLE_W = 2;
    // pin control fields
    localparam int MASIC_PG_DIS_BIT = 0;
    localparam int MASIC_PG_FORCE_BIT = 1;
    localparam int MASIC_STAT_DIS_BIT = 2;
    localparam int MASIC_STAT_A_FORCE_BIT = 3;
    localparam int MASIC_STAT_B_FORCE_BIT = 4;
    // interrupt source bit positions
    localparam int MASIC_SRC_PG = 0;
    localparam int MASIC_SRC_PG_LOST = 1;
    localparam int MASIC_SRC_IAC = 2;
    localparam int MASIC_SRC_VAC = 3;
    localparam int MASIC_SRC_WDOG = 4;
    localparam int MASIC_SRC_CHG = 5;
    localparam int MASIC_SRC_TS = 6;
    localparam int MASIC_SRC_THERMAL_SHUTDOWN = 7;
    localparam int MASIC_SRC_BATOV = 8;
    localparam int MASIC_SRC_DONE = 9;
    localparam int MASIC_NUM_SRC = 10;
    localparam logic [31:0] MASIC_RESET_WORD = 32'h0000_0000;
    // time base
    localparam int MASIC_CLK_HZ = 50_000_000;
    localparam int MASIC_PULSE_US = 256;
    localparam int MASIC_PULSE_CYC = MASIC_PULSE_US * (MASIC_CLK_HZ / 1_000_000);
    typedef enum logic [1:0] {
        MASIC_CHG_OFF,
        MASIC_CHG_RUN,
        MASIC_CHG_DONE,
        MASIC_CHG_FAULT
    } masic_chg_e;
endpackage : masic_pkg

// ==== design/masic_top.sv ====
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - converter may run only if input valid or battery above regulator-good
// - enable bit, one-shot/continuous rate bit, sample field select behaviour
// - one-shot completion clears enable; host must set it again
// - disabled channels skipped; results hold last value or zero
// - channel disabled mid-conversion finishes unless one-shot is left with none enabled; skipped from next sequence
// - one-shot with all channels disabled clears enable
// - one-shot completion sets done status and flag, pulses alert unless masked
// - in continuous mode done status reads zero, done flag unchanged
// - sequencing ignores faults; in continuous mode runs until host clears enable
// - host clearing enable halts at once, results kept
// - switch to one-shot mid-run stops after the current full cycle
// - all channels disabled while running in continuous mode stops after current measurement
// - on battery, enabling converter powers up the regulator rail
// - power good only inside window, both comparators pass, not high-z
// - disable bit detaches power-good pin; force bit pulls it low
// - charge pins: run A on, done B on, fault both, off none
// - disable bit detaches charge pins; two force bits pull each low
// - reverse mode holds both charge pins off
// - unmasked events give active-low 256 us alert pulses; events in one cycle share one pulse, events during a pulse share one more pulse after it
// - sources: pg edges, regulation entry, watchdog, state changes, faults
// - each source has live status, sticky flag and mask
// - status rising edge sets flag; host read clears it
// - current regulation via hw limit pin sets status, flag, alert
module masic_top
    import masic_pkg::*;
#(
    parameter int PULSE_CYCLES = masic_pkg::MASIC_PULSE_CYC,
    parameter int CONV_CYCLES = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic input_voltage_ok,
    input wire logic input_voltage_below_ov,
    input wire logic battery_internal_regulator_rail_ok,
    input wire logic input_undervoltage_pin,
    input wire logic input_overvoltage_pin,
    input wire logic high_impedance_mode,
    input wire logic input_current_regulation,
    input wire logic hw_current_limit_pin,
    input wire logic input_voltage_regulation,
    input wire logic watchdog_expired,
    input wire logic [1:0] charge_state,
    input wire logic [2:0] thermistor_state_field,
    input wire logic thermal_shutdown,
    input wire logic battery_overvoltage,
    input wire logic reverse_mode_active,
    input wire logic conv_valid,
    input wire logic [15:0] conv_data,
    output logic conv_start,
    output logic [2:0] conv_channel,
    output logic [1:0] conv_sample,
    output logic internal_regulator_rail,
    output logic power_good_pin_o,
    output logic power_good_pin_oe,
    output logic charge_status_pin_a_o,
    output logic charge_status_pin_a_oe,
    output logic charge_status_pin_b_o,
    output logic charge_status_pin_b_oe,
    output logic alert_n
);
    import masic_pkg::*;

    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam int PW = $clog2(PULSE_CYCLES + 1);

    initial begin
        if (PULSE_CYCLES < 1 || CONV_CYCLES < 1) begin
            $error("masic_top: cycle counts must be positive");
        end
    end

    typedef enum logic [1:0] {
        MASIC_IDLE,
        MASIC_PICK,
        MASIC_CONV
    } masic_seq_e;

    function automatic logic [3:0] masic_next_ch(input logic [7:0] dis, input logic [3:0] from);
        logic [3:0] r;
        r = 4'h8;
        for (int i = MASIC_NUM_CH - 1; i >= 0; i--) begin
            if (i >= from && !dis[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : masic_next_ch

    logic adc_en_q, oneshot_q;
    logic [1:0] sample_q;
    logic [7:0] ch_dis_q;
    logic [4:0] pin_ctrl_q;
    logic [MASIC_NUM_SRC-1:0] flag_q, mask_q, stat_prev_q, stat_now;
    logic [15:0] result_q [MASIC_NUM_CH];
    masic_seq_e seq_q;
    logic [2:0] ch_q;
    logic [CW-1:0] conv_cnt_q;
    logic [PW-1:0] pulse_cnt_q;
    logic [MASIC_NUM_SRC-1:0] pend_q;
    logic [1:0] chg_prev_q;
    logic [2:0] ts_prev_q;
    logic done_stat_q, done_evt, cycle_end, seq_stop;
    logic acc_q;
    logic [31:0] rdata_q;

    // writes land on the edge where waitrequest is sampled low
    wire logic wr_en = avs_write && acc_q;
    wire logic rd_en = avs_read && !acc_q;
    wire logic [3:0] idx = avs_address[5:2];
    wire logic adc_allowed = input_voltage_ok || battery_internal_regulator_rail_ok;
    wire logic power_good = input_voltage_ok && input_voltage_below_ov
        && input_undervoltage_pin && !input_overvoltage_pin && !high_impedance_mode;
    wire logic [3:0] nxt = masic_next_ch(ch_dis_q, 4'({1'b0, ch_q}) + 4'h1);
    wire logic [3:0] first = masic_next_ch(ch_dis_q, 4'h0);

    // one-cycle waitrequest so every access ends on a known edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_q <= 1'b0;
        end else begin
            acc_q <= (avs_read || avs_write) && !acc_q;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !acc_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= MASIC_RESET_WORD;
        end else if (rd_en) begin
            rdata_q <= MASIC_RESET_WORD;
            if (idx >= MASIC_REG_RESULT0) begin
                rdata_q[15:0] <= result_q[3'(idx - MASIC_REG_RESULT0)];
            end else begin
                unique case (idx)
                    MASIC_REG_ADC_CTRL: rdata_q[3:0] <= {sample_q, oneshot_q, adc_en_q};
                    MASIC_REG_ADC_DIS: rdata_q[7:0] <= ch_dis_q;
                    MASIC_REG_PIN_CTRL: rdata_q[4:0] <= pin_ctrl_q;
                    MASIC_REG_STATUS: rdata_q[MASIC_NUM_SRC-1:0] <= stat_now;
                    MASIC_REG_FLAG: rdata_q[MASIC_NUM_SRC-1:0] <= flag_q;
                    MASIC_REG_MASK: rdata_q[MASIC_NUM_SRC-1:0] <= mask_q;
                    default: rdata_q <= MASIC_RESET_WORD;
                endcase
            end
        end
    end
    assign avs_readdata = rdata_q;

    // sequencer control
    assign cycle_end = seq_q == MASIC_CONV && conv_valid && nxt[3];
    wire logic all_dis = &ch_dis_q;
    assign done_evt = oneshot_q && cycle_end;
    assign seq_stop = (oneshot_q && cycle_end) || (all_dis && oneshot_q);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adc_en_q <= 1'b0;
            oneshot_q <= 1'b0;
            sample_q <= 2'h0;
        end else begin
            if (wr_en && idx == MASIC_REG_ADC_CTRL && avs_byteenable[0]) begin
                adc_en_q <= avs_writedata[MASIC_ADC_EN_BIT];
                oneshot_q <= avs_writedata[MASIC_ADC_ONESHOT_BIT];
                sample_q <= avs_writedata[MASIC_ADC_SAMPLE_LSB +: MASIC_ADC_SAMPLE_W];
            end else if (seq_stop && adc_en_q) begin
                adc_en_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ch_dis_q <= 8'h00;
            pin_ctrl_q <= 5'h00;
            mask_q <= '0;
        end else if (wr_en && avs_byteenable[0]) begin
            if (idx == MASIC_REG_ADC_DIS) ch_dis_q <= avs_writedata[7:0];
            if (idx == MASIC_REG_PIN_CTRL) pin_ctrl_q <= avs_writedata[4:0];
            if (idx == MASIC_REG_MASK) mask_q <= avs_writedata[MASIC_NUM_SRC-1:0];
        end
    end

    // faults are not inputs here on purpose: sequencing ignores them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seq_q <= MASIC_IDLE;
            ch_q <= 3'h0;
            conv_cnt_q <= '0;
        end else if (!adc_en_q || !adc_allowed) begin
            seq_q <= MASIC_IDLE;
        end else begin
            unique case (seq_q)
                MASIC_IDLE, MASIC_PICK: begin
                    if (!first[3]) begin
                        ch_q <= first[2:0];
                        conv_cnt_q <= '0;
                        seq_q <= MASIC_CONV;
                    end else begin
                        seq_q <= MASIC_PICK;
                    end
                end
                MASIC_CONV: begin
                    if (conv_cnt_q != CW'(CONV_CYCLES)) begin
                        conv_cnt_q <= conv_cnt_q + CW'(1);
                    end
                    if (conv_valid) begin
                        // disable sampled only between channels, so current one finishes
                        if (all_dis) begin
                            seq_q <= MASIC_PICK;
                        end else if (nxt[3]) begin
                            seq_q <= MASIC_PICK;
                        end else begin
                            ch_q <= nxt[2:0];
                            conv_cnt_q <= '0;
                        end
                    end
                end
                default: seq_q <= MASIC_IDLE;
            endcase
        end
    end
    // gated so a start cannot slip out in the cycle after enable drops
    assign conv_start = seq_q == MASIC_CONV && conv_cnt_q == '0 && adc_en_q && adc_allowed;
    assign conv_channel = ch_q;
    assign conv_sample = sample_q;
    assign internal_regulator_rail = adc_en_q || !high_impedance_mode && input_voltage_ok;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < MASIC_NUM_CH; i++) result_q[i] <= 16'h0000;
        end else if (seq_q == MASIC_CONV && conv_valid && adc_en_q) begin
            result_q[ch_q] <= conv_data;
        end
    end

    // done status valid in one-shot only; cleared by next enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            done_stat_q <= 1'b0;
        end else if (done_evt) begin
            done_stat_q <= 1'b1;
        end else if (wr_en && idx == MASIC_REG_ADC_CTRL && avs_writedata[MASIC_ADC_EN_BIT]) begin
            done_stat_q <= 1'b0;
        end
    end

    always_comb begin
        stat_now = '0;
        stat_now[MASIC_SRC_PG] = power_good;
        stat_now[MASIC_SRC_PG_LOST] = !power_good;
        stat_now[MASIC_SRC_IAC] = input_current_regulation || hw_current_limit_pin;
        stat_now[MASIC_SRC_VAC] = input_voltage_regulation;
        stat_now[MASIC_SRC_WDOG] = watchdog_expired;
        stat_now[MASIC_SRC_CHG] = charge_state != chg_prev_q;
        stat_now[MASIC_SRC_TS] = thermistor_state_field != ts_prev_q;
        stat_now[MASIC_SRC_THERMAL_SHUTDOWN] = thermal_shutdown;
        stat_now[MASIC_SRC_BATOV] = battery_overvoltage;
        stat_now[MASIC_SRC_DONE] = done_stat_q && oneshot_q;
    end

    wire logic [MASIC_NUM_SRC-1:0] rise = stat_now & ~stat_prev_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            // power-lost idles high; avoids a false edge after reset
            stat_prev_q <= MASIC_NUM_SRC'(1) << MASIC_SRC_PG_LOST;
            chg_prev_q <= 2'h0;
            ts_prev_q <= 3'h0;
            flag_q <= '0;
        end else begin
            stat_prev_q <= stat_now;
            chg_prev_q <= charge_state;
            ts_prev_q <= thermistor_state_field;
            // set beats the read clear
            flag_q <= ((rd_en && idx == MASIC_REG_FLAG) ? '0 : flag_q) | rise;
        end
    end

    // one pending bit per source; a queued event waits for the pulse to finish
    wire logic [MASIC_NUM_SRC-1:0] new_evt = rise & ~mask_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_q <= '0;
            pulse_cnt_q <= '0;
        end else begin
            if (pulse_cnt_q != '0) begin
                pulse_cnt_q <= pulse_cnt_q - PW'(1);
                pend_q <= pend_q | new_evt;
            end else if ((pend_q | new_evt) != '0) begin
                pulse_cnt_q <= PW'(PULSE_CYCLES);
                pend_q <= '0;
            end
        end
    end
    assign alert_n = pulse_cnt_q == '0;

    masic_chg_e chg;
    assign chg = masic_chg_e'(charge_state);
    logic stat_a_on, stat_b_on;
    always_comb begin
        stat_a_on = 1'b0;
        stat_b_on = 1'b0;
        if (reverse_mode_active) begin
            stat_a_on = 1'b0;
        end else if (pin_ctrl_q[MASIC_STAT_DIS_BIT]) begin
            stat_a_on = pin_ctrl_q[MASIC_STAT_A_FORCE_BIT];
            stat_b_on = pin_ctrl_q[MASIC_STAT_B_FORCE_BIT];
        end else begin
            unique case (chg)
                MASIC_CHG_RUN: stat_a_on = 1'b1;
                MASIC_CHG_DONE: stat_b_on = 1'b1;
                MASIC_CHG_FAULT: begin
                    stat_a_on = 1'b1;
                    stat_b_on = 1'b1;
                end
                MASIC_CHG_OFF: stat_a_on = 1'b0;
            endcase
        end
    end

    // open drain: output always low, enable means pull low
    logic pg_on_q, sa_q, sb_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pg_on_q <= 1'b0;
            sa_q <= 1'b0;
            sb_q <= 1'b0;
        end else begin
            pg_on_q <= pin_ctrl_q[MASIC_PG_DIS_BIT] ? pin_ctrl_q[MASIC_PG_FORCE_BIT]
                : power_good;
            sa_q <= stat_a_on;
            sb_q <= stat_b_on;
        end
    end
    assign power_good_pin_o = 1'b0;
    assign power_good_pin_oe = pg_on_q;
    assign charge_status_pin_a_o = 1'b0;
    assign charge_status_pin_a_oe = sa_q;
    assign charge_status_pin_b_o = 1'b0;
    assign charge_status_pin_b_oe = sb_q;
endmodule : masic_top

// ==== bench/masic_assertions.sv ====
`timescale 1ns/100ps
module masic_chk #(
    parameter int PULSE_CYCLES = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic input_voltage_ok,
    input wire logic input_voltage_below_ov,
    input wire logic battery_internal_regulator_rail_ok,
    input wire logic input_undervoltage_pin,
    input wire logic input_overvoltage_pin,
    input wire logic high_impedance_mode,
    input wire logic [1:0] charge_state,
    input wire logic reverse_mode_active,
    input wire logic conv_start,
    input wire logic [2:0] conv_channel,
    input wire logic internal_regulator_rail,
    input wire logic power_good_pin_oe,
    input wire logic charge_status_pin_a_oe,
    input wire logic charge_status_pin_b_oe,
    input wire logic alert_n
);
    import masic_pkg::*;
    logic [4:0] pin_q;
    logic [7:0] dis_q;
    logic [15:0] low_q;
    logic wr0;
    logic pg_ok;
    // writes land on the edge where waitrequest is sampled low
    assign wr0 = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign pg_ok = input_voltage_ok && input_voltage_below_ov && input_undervoltage_pin &&
        !input_overvoltage_pin && !high_impedance_mode;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_q <= '0;
            dis_q <= '0;
        end else if (wr0 && avs_address[5:2] == MASIC_REG_PIN_CTRL) begin
            pin_q <= avs_writedata[4:0];
        end else if (wr0 && avs_address[5:2] == MASIC_REG_ADC_DIS) begin
            dis_q <= avs_writedata[7:0];
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || alert_n) begin
            low_q <= '0;
        end else begin
            low_q <= low_q + 16'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_wait;
        ($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("waitrequest phase wrong");
    property p_gate;
        conv_start |-> input_voltage_ok || battery_internal_regulator_rail_ok;
    endproperty
    a_gate: assert property (p_gate) else $error("conversion without supply");
    property p_rail;
        conv_start |-> internal_regulator_rail;
    endproperty
    a_rail: assert property (p_rail) else $error("rail off while converting");
    // two-cycle settle avoids flagging a channel chosen just before the write
    property p_skip;
        conv_start && dis_q == $past(dis_q, 2) |-> !dis_q[conv_channel];
    endproperty
    a_skip: assert property (p_skip) else $error("disabled channel converted");
    property p_pg_map;
        !pin_q[0] |=> power_good_pin_oe == $past(pg_ok);
    endproperty
    a_pg_map: assert property (p_pg_map) else $error("power good pin wrong");
    property p_pg_force;
        pin_q[0] |=> power_good_pin_oe == $past(pin_q[1]);
    endproperty
    a_pg_force: assert property (p_pg_force) else $error("power good force wrong");
    property p_stat_map;
        !pin_q[2] && !reverse_mode_active |=>
            {charge_status_pin_a_oe, charge_status_pin_b_oe} == $past({charge_state[0], charge_state[1]});
    endproperty
    a_stat_map: assert property (p_stat_map) else $error("charge pins wrong");
    property p_stat_force;
        pin_q[2] && !reverse_mode_active |=>
            {charge_status_pin_a_oe, charge_status_pin_b_oe} == $past({pin_q[3], pin_q[4]});
    endproperty
    a_stat_force: assert property (p_stat_force) else $error("charge force wrong");
    property p_reverse;
        reverse_mode_active |=> !charge_status_pin_a_oe && !charge_status_pin_b_oe;
    endproperty
    a_reverse: assert property (p_reverse) else $error("charge pins on in reverse");
    property p_alert;
        $rose(alert_n) |-> low_q == 16'(PULSE_CYCLES);
    endproperty
    a_alert: assert property (p_alert) else $error("alert pulse width wrong");
endmodule : masic_chk
bind masic_top masic_chk #(.PULSE_CYCLES(PULSE_CYCLES)) masic_chk_i (.*);

// ==== bench/masic_conv_model.sv ====
`timescale 1ns/100ps
module masic_conv_model (
    input wire logic clk,
    input wire logic conv_start,
    input wire logic [2:0] conv_channel,
    output logic conv_valid,
    output logic [15:0] conv_data
);
    logic busy_q = 1'b0;
    logic slow_q = 1'b0;
    logic [2:0] wait_q = '0;
    logic [2:0] ch_q = '0;
    initial conv_valid = 1'b0;
    initial conv_data = '0;
    // alternates prompt and slow answers; data bus toggles when not valid
    always @(posedge clk) begin
        conv_valid <= 1'b0;
        conv_data <= ~conv_data;
        if (conv_start) begin
            busy_q <= 1'b1;
            ch_q <= conv_channel;
            wait_q <= slow_q ? 3'h5 : 3'h1;
            slow_q <= !slow_q;
        end else if (busy_q && wait_q == 3'h0) begin
            busy_q <= 1'b0;
            conv_valid <= 1'b1;
            conv_data <= {5'h15, ch_q, 8'h3c};
        end else if (busy_q) begin
            wait_q <= wait_q - 3'h1;
        end
    end
endmodule : masic_conv_model

// ==== bench/masic_top_tb.sv ====
`timescale 1ns/100ps
module masic_top_tb;
    import masic_pkg::*;
    localparam int PW = 8;
    logic clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [5:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata;
    logic [3:0] avs_byteenable = 4'hf;
    logic avs_waitrequest, conv_valid, conv_start, internal_regulator_rail, alert_n;
    logic input_voltage_ok = 0, input_voltage_below_ov = 0, battery_internal_regulator_rail_ok = 0;
    logic input_undervoltage_pin = 0, input_overvoltage_pin = 0, high_impedance_mode = 0;
    logic reverse_mode_active = 0;
    logic [1:0] charge_state = '0, conv_sample;
    logic [2:0] thermistor_state_field = '0, conv_channel;
    logic [15:0] conv_data;
    logic [5:0] lv = '0;
    logic [4:0] pc = '0;
    logic power_good_pin_o, power_good_pin_oe, charge_status_pin_a_o, charge_status_pin_a_oe;
    logic charge_status_pin_b_o, charge_status_pin_b_oe;
    wire logic input_current_regulation = lv[0];
    wire logic hw_current_limit_pin = lv[1];
    wire logic input_voltage_regulation = lv[2];
    wire logic watchdog_expired = lv[3];
    wire logic thermal_shutdown = lv[4];
    wire logic battery_overvoltage = lv[5];
    int error_cnt = 0, num_checks = 0;
    int bp[8] = '{MASIC_SRC_IAC, MASIC_SRC_IAC, MASIC_SRC_VAC, MASIC_SRC_WDOG,
        MASIC_SRC_THERMAL_SHUTDOWN, MASIC_SRC_BATOV, MASIC_SRC_CHG, MASIC_SRC_TS};
    masic_top #(.PULSE_CYCLES(PW)) masic_top_i (.*);
    masic_conv_model masic_conv_model_i (.*);
    initial forever #10 clk = ~clk;
    function automatic logic [15:0] res_exp(input int ch);
        return {5'h15, 3'(ch), 8'h3c};
    endfunction : res_exp
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic we, input logic [3:0] idx, input logic [31:0] wd,
            output logic [31:0] rd);
        int n = 0;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= !we;
        avs_write <= we;
        avs_writedata <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        rd = avs_readdata;
        if (n >= 100) chk("waitrequest", 32'h0, 32'h1);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask : wr
    task automatic rdc(input string nm, input logic [3:0] idx, input logic [31:0] e,
            input logic [31:0] m);
        logic [31:0] d;
        bus(1'b0, idx, 32'h0, d);
        chk(nm, e & m, d & m);
    endtask : rdc
    task automatic wait_idle();
        logic [31:0] d;
        int n = 0;
        do begin
            bus(1'b0, MASIC_REG_ADC_CTRL, 32'h0, d);
            n++;
        end while (d[0] !== 1'b0 && n < 200);
        chk("adc enable", 32'h0, {31'h0, d[0]});
    endtask : wait_idle
    task automatic pulse(input logic exp_pulse);
        int n = 0, w = 0;
        while (alert_n === 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        while (alert_n === 1'b0 && w < 200) begin
            @(posedge clk);
            w++;
        end
        chk("alert width", exp_pulse ? 32'(PW) : 32'h0, 32'(w));
    endtask : pulse
    task automatic starts(input logic exp_any);
        int c = 0;
        repeat (60) begin
            @(posedge clk);
            c += int'(conv_start === 1'b1);
        end
        chk("conversions seen", {31'h0, exp_any}, {31'h0, c != 0});
    endtask : starts
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        void'($urandom(62660));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i++) rdc("reset value", 4'(i), (4'(i) == MASIC_REG_STATUS) ?
            32'h1 << MASIC_SRC_PG_LOST : 32'h0, '1);
        wr(4'h6, '1);
        rdc("unmapped", 4'h6, 32'h0, '1);
        wr(MASIC_REG_MASK, 32'h3ff);
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            charge_state <= 2'($urandom);
            reverse_mode_active <= ($urandom % 4) == 0;
            {input_voltage_ok, input_voltage_below_ov, input_undervoltage_pin,
                input_overvoltage_pin, high_impedance_mode} <= 5'($urandom);
            if (i % 4 == 0) pc = 5'($urandom);
            if (i % 4 == 0) wr(MASIC_REG_PIN_CTRL, {27'h0, pc});
            repeat (2) @(posedge clk);
            chk("pins", {3'h0, pc[0] ? pc[1] : input_voltage_ok && input_voltage_below_ov &&
                input_undervoltage_pin && !input_overvoltage_pin && !high_impedance_mode,
                reverse_mode_active ? 2'b00 : pc[2] ? {pc[3], pc[4]} : {charge_state[0],
                charge_state[1]}}, {26'h0, power_good_pin_o, charge_status_pin_a_o,
                charge_status_pin_b_o, power_good_pin_oe, charge_status_pin_a_oe,
                charge_status_pin_b_oe});
        end
        {input_voltage_ok, input_voltage_below_ov, input_undervoltage_pin,
            input_overvoltage_pin, high_impedance_mode, charge_state, reverse_mode_active} <= '0;
        repeat (4) @(posedge clk);
        rdc("flag drain", MASIC_REG_FLAG, 32'h0, 32'hffff_ff9c);
        wr(MASIC_REG_MASK, 32'h0);
        rdc("flag clear", MASIC_REG_FLAG, 32'h0, '1);
        {input_voltage_ok, input_voltage_below_ov, input_undervoltage_pin} <= 3'h7;
        pulse(1'b1);
        rdc("status", MASIC_REG_STATUS, 32'h1, 32'h3);
        rdc("flag", MASIC_REG_FLAG, 32'h1, '1);
        rdc("flag reread", MASIC_REG_FLAG, 32'h0, '1);
        high_impedance_mode <= 1'b1;
        pulse(1'b1);
        rdc("flag", MASIC_REG_FLAG, 32'h2, '1);
        for (int k = 0; k < 8; k++) begin
            if (k < 6) lv <= 6'(1 << k);
            else if (k == 6) charge_state <= 2'h1;
            else thermistor_state_field <= 3'($urandom_range(7, 1));
            pulse(1'b1);
            rdc("flag", MASIC_REG_FLAG, 32'h1 << bp[k], '1);
            lv <= '0;
            @(posedge clk);
        end
        wr(MASIC_REG_MASK, 32'h1 << MASIC_SRC_IAC);
        lv <= 6'h2;
        pulse(1'b0);
        rdc("masked flag", MASIC_REG_FLAG, 32'h1 << MASIC_SRC_IAC, '1);
        lv <= '0;
        wr(MASIC_REG_MASK, 32'h0);
        input_voltage_ok <= 1'b0;
        battery_internal_regulator_rail_ok <= 1'b1;
        wr(MASIC_REG_ADC_DIS, 32'hf0);
        wr(MASIC_REG_ADC_CTRL, 32'h7);
        @(posedge clk);
        chk("sample field", 32'h1, {30'h0, conv_sample});
        pulse(1'b1);
        wait_idle();
        rdc("done status", MASIC_REG_STATUS, 32'h200, 32'h200);
        wr(MASIC_REG_ADC_DIS, 32'h0f);
        wr(MASIC_REG_ADC_CTRL, 32'h1);
        lv <= 6'h10;
        starts(1'b1);
        rdc("done status", MASIC_REG_STATUS, 32'h0, 32'h200);
        rdc("done flag", MASIC_REG_FLAG, 32'h200, 32'h200);
        wr(MASIC_REG_ADC_CTRL, 32'h3);
        wait_idle();
        for (int c = 0; c < 8; c++) rdc("result", MASIC_REG_RESULT0 + 4'(c),
            32'(res_exp(c)), '1);
        wr(MASIC_REG_ADC_DIS, 32'hff);
        wr(MASIC_REG_ADC_CTRL, 32'h3);
        wait_idle();
        wr(MASIC_REG_ADC_DIS, 32'h0);
        wr(MASIC_REG_ADC_CTRL, 32'h1);
        wr(MASIC_REG_ADC_DIS, 32'hff);
        starts(1'b0);
        wr(MASIC_REG_ADC_DIS, 32'h0);
        wr(MASIC_REG_ADC_CTRL, 32'h0);
        starts(1'b0);
        battery_internal_regulator_rail_ok <= 1'b0;
        wr(MASIC_REG_ADC_CTRL, 32'h1);
        starts(1'b0);
        report_and_stop();
    end
endmodule : masic_top_tb
